// ---- inc/fill_pkg.sv ----
// constants for the gravimetric fill sequencer
// assumes a 40 MHz mclk and signed weights in display intervals
package fill_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned STALL_TIME_MS = 4000;
  localparam int unsigned STALL_CYCLES  = CLK_HZ / 1000 * STALL_TIME_MS;
  localparam int unsigned W_BITS        = 20;
  localparam logic [19:0] STALL_DELTA   = 20'h00005;
  localparam logic [19:0] REDOSE_STEP   = 20'h00002;
  localparam logic [19:0] STEP_GUARD    = 20'h00001;
  localparam int unsigned STEP_CYCLES   = 4000;
  // apb byte offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_TARGET  = 8'h04;
  localparam logic [7:0] A_TOL     = 8'h08;
  localparam logic [7:0] A_TAREMIN = 8'h0c;
  localparam logic [7:0] A_TAREMAX = 8'h10;
  localparam logic [7:0] A_WEIGHT  = 8'h14;
  localparam logic [7:0] A_STATUS  = 8'h18;
  localparam logic [7:0] A_IRQ     = 8'h1c;
  localparam logic [7:0] A_MASK    = 8'h20;
  localparam logic [7:0] A_SHUT    = 8'h24;
  // ctrl bits
  localparam int C_TWO    = 0;
  localparam int C_CORR   = 1;
  localparam int C_REDOSE = 2;
  localparam int C_FILLIN = 3;
  localparam int C_START  = 4;
  localparam int C_ABORT  = 5;
  localparam logic [5:0] CTRL_RST = 6'h0f;
  // irq bits
  localparam int I_DONE  = 0;
  localparam int I_STALL = 1;
  localparam int I_TARE  = 2;
  localparam int I_BITS  = 3;
  typedef enum logic [3:0] {
    S_IDLE, S_COARSE, S_FINE, S_SETTLE, S_REDOSE, S_REWAIT, S_JUDGE, S_DONE
  } state_t;
endpackage

// ---- hdl/fill_seq.sv ----
// gravimetric fill sequencer with apb registers and valve/lamp outputs
// assumes weight and stable come from logic on mclk; start key is a pin
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fill_seq (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [19:0] weight,
  input  wire logic        stable,
  input  wire logic        start_key_n,
  output logic             coarse_on,
  output logic             fine_on,
  output logic             ready_lamp,
  output logic             under_lamp,
  output logic             intol_lamp,
  output logic             over_lamp,
  output logic             irq
);
  localparam int I_BITS = fill_pkg::I_BITS;

  // configuration registers
  logic [5:0]        ctrl_q;
  logic [19:0]       target_q;
  logic [19:0]       tol_q;
  logic [19:0]       tmin_q;
  logic [19:0]       tmax_q;

  // fill bookkeeping
  logic [19:0]       shut_q;
  logic [19:0]       coarse_pt_q;
  logic [19:0]       tare_q;
  logic [19:0]       ref_q;
  logic              known_q;
  logic              learn_q;
  logic              pass_q;
  fill_pkg::state_t  st_q;
  logic [31:0]       tmr_q;

  // events and interrupt
  logic [I_BITS-1:0] ist_q;
  logic [I_BITS-1:0] imask_q;
  logic [I_BITS-1:0] ev;

  // start key synchroniser
  logic              key_s1_q;
  logic              key_s2_q;
  logic              key_d_q;

  // decoded strobes and compare values
  logic              wr;
  logic              rd;
  logic              wr_ctrl;
  logic              wr_irq;
  logic              abort_req;
  logic              key_press;
  logic              start_req;
  logic              err_addr;
  logic              tare_ok;
  logic [19:0]       net;
  logic [19:0]       goal;
  logic [19:0]       coarse_goal;

  // amount moved so far, signed by direction
  function automatic logic [19:0] moved(input logic [19:0] w, input logic [19:0] t,
                                        input logic fin);
    moved = fin ? w - t : t - w;
  endfunction

  function automatic logic [19:0] half(input logic [19:0] v);
    half = {v[19], v[19:1]};
  endfunction

  // signed compares keep an overshoot past zero from wrapping
  function automatic logic below_band(input logic [19:0] n, input logic [19:0] t,
                                      input logic [19:0] b);
    below_band = $signed(n) < $signed(t - b);
  endfunction

  function automatic logic above_band(input logic [19:0] n, input logic [19:0] t,
                                      input logic [19:0] b);
    above_band = $signed(n) > $signed(t + b);
  endfunction

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign net = moved(weight, tare_q, ctrl_q[fill_pkg::C_FILLIN]);
  assign goal = known_q ? shut_q : half(target_q);
  // first learn pass stops coarse at a quarter of target
  assign coarse_goal = known_q ? coarse_pt_q : half(half(target_q));
  assign wr_ctrl   = wr && paddr == fill_pkg::A_CTRL;
  assign wr_irq    = wr && paddr == fill_pkg::A_IRQ;
  assign abort_req = wr_ctrl && pwdata[fill_pkg::C_ABORT];
  // an empty platform reads zero: no container
  assign tare_ok   = weight >= tmin_q && weight <= tmax_q && weight != 20'h0;

  // start key contact, active low, two-flop synchronised
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // open contact level, so no false press right after reset
      key_s1_q <= 1'b1;
      key_s2_q <= 1'b1;
      key_d_q  <= 1'b1;
    end else begin
      key_s1_q <= start_key_n;
      key_s2_q <= key_s1_q;
      key_d_q  <= key_s2_q;
    end
  end

  assign key_press = key_d_q & ~key_s2_q;
  assign start_req = key_press | (wr_ctrl && pwdata[fill_pkg::C_START]);

  always_comb begin
    unique case (paddr)
      fill_pkg::A_CTRL, fill_pkg::A_TARGET, fill_pkg::A_TOL, fill_pkg::A_TAREMIN,
      fill_pkg::A_TAREMAX, fill_pkg::A_WEIGHT, fill_pkg::A_STATUS, fill_pkg::A_IRQ,
      fill_pkg::A_MASK, fill_pkg::A_SHUT: err_addr = 1'b0;
      default: err_addr = 1'b1;
    endcase
  end

  // apb: one wait-free access phase, reads captured in setup
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & err_addr;
      if (rd) begin
        unique case (paddr)
          fill_pkg::A_CTRL:    prdata <= {26'h0, ctrl_q};
          fill_pkg::A_TARGET:  prdata <= {12'h0, target_q};
          fill_pkg::A_TOL:     prdata <= {12'h0, tol_q};
          fill_pkg::A_TAREMIN: prdata <= {12'h0, tmin_q};
          fill_pkg::A_TAREMAX: prdata <= {12'h0, tmax_q};
          fill_pkg::A_WEIGHT:  prdata <= {12'h0, weight};
          fill_pkg::A_STATUS:  prdata <= {22'h0, known_q, learn_q, 1'b0, st_q, over_lamp,
                                          intol_lamp, under_lamp};
          fill_pkg::A_IRQ:     prdata <= {29'h0, ist_q};
          fill_pkg::A_MASK:    prdata <= {29'h0, imask_q};
          fill_pkg::A_SHUT:    prdata <= {12'h0, shut_q};
          default:             prdata <= 32'h0;
        endcase
      end
    end
  end

  // configuration; start/abort bits are self-clearing strobes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q   <= fill_pkg::CTRL_RST;
      target_q <= 20'h0;
      tol_q    <= 20'h0;
      tmin_q   <= 20'h0;
      tmax_q   <= 20'h0;
      imask_q  <= '0;
    end else if (wr) begin
      unique case (paddr)
        fill_pkg::A_CTRL:    ctrl_q <= {2'b00, pwdata[3:0]};
        fill_pkg::A_TARGET:  target_q <= pwdata[19:0];
        fill_pkg::A_TOL:     tol_q <= pwdata[19:0];
        fill_pkg::A_TAREMIN: tmin_q <= pwdata[19:0];
        fill_pkg::A_TAREMAX: tmax_q <= pwdata[19:0];
        fill_pkg::A_MASK:    imask_q <= pwdata[I_BITS-1:0];
        default: ;
      endcase
    end
  end

  // sticky events, set wins over write-one clear
  always_ff @(posedge mclk) begin
    if (!rst_n)
      ist_q <= '0;
    else if (wr_irq)
      ist_q <= (ist_q & ~pwdata[I_BITS-1:0]) | ev;
    else
      ist_q <= ist_q | ev;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) irq <= 1'b0;
    else        irq <= |(ist_q & imask_q);
  end

  // sequencer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q        <= fill_pkg::S_IDLE;
      tmr_q       <= 32'h0;
      tare_q      <= 20'h0;
      ref_q       <= 20'h0;
      shut_q      <= 20'h0;
      coarse_pt_q <= 20'h0;
      known_q     <= 1'b0;
      learn_q     <= 1'b0;
      pass_q      <= 1'b0;
      coarse_on   <= 1'b0;
      fine_on     <= 1'b0;
      ready_lamp  <= 1'b1;
      under_lamp  <= 1'b0;
      intol_lamp  <= 1'b0;
      over_lamp   <= 1'b0;
      ev          <= '0;
    end else begin
      ev <= '0;
      if (abort_req) begin
        st_q      <= fill_pkg::S_IDLE;
        coarse_on <= 1'b0;
        fine_on   <= 1'b0;
        ready_lamp <= 1'b1;
      end else begin
        unique case (st_q)
          fill_pkg::S_IDLE, fill_pkg::S_DONE: if (start_req) begin
            if (!tare_ok) begin
              ev[fill_pkg::I_TARE] <= 1'b1;
            end else begin
              tare_q     <= weight;
              ref_q      <= weight;
              tmr_q      <= 32'h0;
              learn_q    <= ~known_q;
              pass_q     <= 1'b0;
              ready_lamp <= 1'b0;
              under_lamp <= 1'b0;
              intol_lamp <= 1'b0;
              over_lamp  <= 1'b0;
              if (ctrl_q[fill_pkg::C_TWO]) begin
                coarse_on <= 1'b1;
                st_q      <= fill_pkg::S_COARSE;
              end else begin
                fine_on <= 1'b1;
                st_q    <= fill_pkg::S_FINE;
              end
            end
          end
          fill_pkg::S_COARSE, fill_pkg::S_FINE: begin
            tmr_q <= tmr_q + 32'h1;
            if (moved(weight, ref_q, ctrl_q[fill_pkg::C_FILLIN]) >= fill_pkg::STALL_DELTA) begin
              ref_q <= weight;
              tmr_q <= 32'h0;
            end
            if (tmr_q >= fill_pkg::STALL_CYCLES - 1) begin
              coarse_on <= 1'b0;
              fine_on   <= 1'b0;
              ready_lamp <= 1'b1;
              ev[fill_pkg::I_STALL] <= 1'b1;
              st_q <= fill_pkg::S_IDLE;
            end else if (st_q == fill_pkg::S_COARSE) begin
              if ($signed(net) >= $signed(coarse_goal)) begin
                coarse_on <= 1'b0;
                fine_on   <= 1'b1;
                st_q      <= fill_pkg::S_FINE;
              end
            end else if ($signed(net) >= $signed(goal)) begin
              fine_on <= 1'b0;
              st_q    <= fill_pkg::S_SETTLE;
            end
          end
          fill_pkg::S_SETTLE: if (stable) begin
            if (learn_q && !pass_q) begin
              // learn: trailing flow past the first close gives the shutoff
              shut_q      <= target_q - (net - half(target_q));
              coarse_pt_q <= half(target_q);
              pass_q      <= 1'b1;
              known_q     <= 1'b1;
              tmr_q       <= 32'h0;
              ref_q       <= weight;
              if (ctrl_q[fill_pkg::C_TWO]) begin
                coarse_on <= 1'b1;
                st_q      <= fill_pkg::S_COARSE;
              end else begin
                fine_on <= 1'b1;
                st_q    <= fill_pkg::S_FINE;
              end
            end else if (ctrl_q[fill_pkg::C_REDOSE] && below_band(net, target_q, tol_q)) begin
              fine_on <= 1'b1;
              tmr_q   <= 32'h0;
              st_q    <= fill_pkg::S_REDOSE;
            end else begin
              st_q <= fill_pkg::S_JUDGE;
            end
          end
          fill_pkg::S_REDOSE: begin
            // short pulse only; small steps avoid overshoot
            tmr_q <= tmr_q + 32'h1;
            if (tmr_q >= fill_pkg::STEP_CYCLES - 1) begin
              fine_on <= 1'b0;
              st_q    <= fill_pkg::S_SETTLE;
            end
          end
          fill_pkg::S_JUDGE: begin
            under_lamp <= below_band(net, target_q, tol_q);
            over_lamp  <= above_band(net, target_q, tol_q);
            intol_lamp <= !below_band(net, target_q, tol_q)
                          && !above_band(net, target_q, tol_q);
            if (ctrl_q[fill_pkg::C_CORR])
              shut_q <= shut_q + half(target_q - net);
            ready_lamp <= 1'b1;
            learn_q    <= 1'b0;
            ev[fill_pkg::I_DONE] <= 1'b1;
            st_q <= fill_pkg::S_DONE;
          end
          default: st_q <= fill_pkg::S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/fill_seq_checker.sv ----
// port assertions for the fill sequencer
// assumes an apb master with setup then access phases
`timescale 1ns/1ps
`default_nettype none
module fill_seq_checker (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        coarse_on,
  input wire logic        fine_on,
  input wire logic        ready_lamp,
  input wire logic        under_lamp,
  input wire logic        intol_lamp,
  input wire logic        over_lamp,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_reset_quiet: assert property ($rose(rst_n) |-> !coarse_on && !fine_on && ready_lamp)
    else $error("outputs not idle after reset");
  a_zero_wait: assert property (s_setup ##1 s_access |-> pready)
    else $error("no ready in first access cycle");
  a_pready_once: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside a single access cycle");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && paddr <= 8'h24 && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access refused");
  a_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:20] == 12'h000)
    else $error("upper read bits not zero");
  a_one_verdict: assert property ($onehot0({under_lamp, intol_lamp, over_lamp}))
    else $error("more than one verdict lamp");
  a_fine_alone: assert property (fine_on |-> !coarse_on)
    else $error("fine feed open with coarse");
  a_busy_not_ready: assert property ((coarse_on || fine_on) |-> !ready_lamp)
    else $error("ready lamp lit while a feed is open");
  a_busy_no_verdict: assert property ((coarse_on || fine_on) |->
    !under_lamp && !intol_lamp && !over_lamp) else $error("verdict lamp lit during feed");
endmodule
bind fill_seq fill_seq_checker fill_seq_checker_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .coarse_on(coarse_on), .fine_on(fine_on), .ready_lamp(ready_lamp),
  .under_lamp(under_lamp), .intol_lamp(intol_lamp), .over_lamp(over_lamp), .irq(irq));
`default_nettype wire

// ---- bench/plant_model.sv ----
// plant: valves pour onto the scale, or draw off it when fill_in is low; start key contact
// assumes valve levels high while open, one mclk
`timescale 1ns/1ps
`default_nettype none
module plant_model (
  input  wire logic        mclk,
  input  wire logic        load,
  input  wire logic [19:0] load_w,
  input  wire logic        fill_in,
  input  wire logic        key_req,
  input  wire logic        coarse_on,
  input  wire logic        fine_on,
  output logic      [19:0] weight,
  output logic             stable,
  output logic             start_key_n
);
  logic [19:0] w_q     = 20'h0;
  logic [3:0]  tick_q  = 4'h0;
  logic [3:0]  key_q   = 4'h0;
  logic [1:0]  drip_q  = 2'h0;
  logic [5:0]  quiet_q = 6'h0;
  logic [3:0]  step;
  logic        open;
  assign open = coarse_on | fine_on;
  // a closed valve still drips a few intervals
  assign step = coarse_on ? 4'h8 : (fine_on || drip_q != 2'h0) ? 4'h1 : 4'h0;
  assign weight = w_q;
  always_ff @(posedge mclk) begin
    tick_q <= tick_q + 4'h1;
    if (load) w_q <= load_w;
    else if (tick_q[1:0] == 2'h3) w_q <= fill_in ? w_q + 20'(step) : w_q - 20'(step);
  end
  always_ff @(posedge mclk) begin
    if (open) drip_q <= 2'h3;
    else if (tick_q[1:0] == 2'h3 && drip_q != 2'h0) drip_q <= drip_q - 2'h1;
  end
  always_ff @(posedge mclk) begin
    if (open || load || drip_q != 2'h0) quiet_q <= 6'h0;
    else if (quiet_q != 6'h3f) quiet_q <= quiet_q + 6'h1;
  end
  assign stable = (quiet_q == 6'h3f);
  always_ff @(posedge mclk) begin
    if (key_req) key_q <= 4'hf;
    else if (key_q != 4'h0) key_q <= key_q - 4'h1;
  end
  // contact to ground: low only while held
  assign start_key_n = (key_q == 4'h0);
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the fill sequencer
// assumes plant_model stands for valves and start key
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, stable, start_key_n, irq, pc, pf;
  logic        coarse_on, fine_on, ready_lamp, under_lamp, intol_lamp, over_lamp;
  logic        load = 1'b0, fill_in = 1'b1, key_req = 1'b0;
  logic [19:0] weight, load_w = 20'h0, tare, cut;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, cc, fc;
  integer      seed = 32'ha93614ca;
  initial forever #12.5 mclk = ~mclk;
  fill_seq fill_seq_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .weight(weight), .stable(stable), .start_key_n(start_key_n),
    .coarse_on(coarse_on), .fine_on(fine_on), .ready_lamp(ready_lamp),
    .under_lamp(under_lamp), .intol_lamp(intol_lamp), .over_lamp(over_lamp), .irq(irq));
  plant_model plant_model_i (.mclk(mclk), .load(load), .load_w(load_w), .fill_in(fill_in),
    .key_req(key_req), .coarse_on(coarse_on), .fine_on(fine_on), .weight(weight),
    .stable(stable), .start_key_n(start_key_n));
  task automatic report_and_stop;
    $display("mismatches %0d of %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected at %0t: %h vs %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ld(input logic [19:0] w);
    @(posedge mclk);
    load <= 1'b1;
    load_w <= w;
    @(posedge mclk);
    load <= 1'b0;
    repeat (80) @(posedge mclk);
  endtask
  // band is target 2000 plus or minus 300
  function automatic logic [2:0] verdict(input logic [19:0] w, t, input logic fi);
    logic [19:0] n;
    n = fi ? w - t : t - w;
    if (n < 20'h006a4) return 3'h1;
    if (n > 20'h008fc) return 3'h4;
    return 3'h2;
  endfunction
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    apb(fill_pkg::A_CTRL, 1'b0, 32'h0);
    chk(q, 32'h0000000f);
    apb(fill_pkg::A_STATUS, 1'b0, 32'h0);
    chk(q[9], 1'b0);
    chk(ready_lamp, 1'b1);
    apb(8'h28, 1'b0, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0);
    $display("reset test done");
    apb(fill_pkg::A_TAREMIN, 1'b1, 32'h64);
    apb(fill_pkg::A_TAREMAX, 1'b1, 32'h3000);
    apb(fill_pkg::A_MASK, 1'b1, 32'h7);
    for (int i = 0; i < 3; i++) begin
      ld(i == 0 ? 20'h00032 + 20'({$random(seed)} % 40) : i == 1 ? 20'h032c8 : 20'h0);
      if (i == 2) key_req <= 1'b1;
      else apb(fill_pkg::A_CTRL, 1'b1, 32'h1f);
      @(posedge mclk);
      key_req <= 1'b0;
      repeat (40) @(posedge mclk);
      chk(coarse_on | fine_on, 1'b0);
      chk(irq, 1'b1);
      apb(fill_pkg::A_IRQ, 1'b1, 32'h4);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
    end
    $display("tare test done");
    for (int m = 0; m < 3; m++) begin
      // fresh reset per fill so every mode runs its learn pass
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      apb(fill_pkg::A_STATUS, 1'b0, 32'h0);
      chk(q[9], 1'b0);
      apb(fill_pkg::A_TAREMIN, 1'b1, 32'h64);
      apb(fill_pkg::A_TAREMAX, 1'b1, 32'h3000);
      apb(fill_pkg::A_MASK, 1'b1, 32'h7);
      fill_in <= (m != 2);
      tare = (m == 2) ? 20'h01770 : 20'h00064 + 20'({$random(seed)} % 256);
      ld(tare);
      apb(fill_pkg::A_TARGET, 1'b1, 32'h7d0);
      apb(fill_pkg::A_TOL, 1'b1, 32'h12c);
      apb(fill_pkg::A_CTRL, 1'b1, {28'h1, m != 2, 2'h3, m != 1});
      cc = 0;
      fc = 0;
      pc = 1'b0;
      pf = 1'b0;
      cut = 20'h0;
      while (irq !== 1'b1) begin
        @(posedge mclk);
        if (coarse_on === 1'b1 && !pc) cc++;
        if (fine_on === 1'b1 && !pf) fc++;
        if (cut == 0 && (pc || pf) && !coarse_on && !fine_on) cut = weight - tare;
        pc = coarse_on;
        pf = fine_on;
      end
      apb(fill_pkg::A_IRQ, 1'b0, 32'h0);
      chk(q[0], 1'b1);
      apb(fill_pkg::A_IRQ, 1'b1, 32'h7);
      chk({over_lamp, intol_lamp, under_lamp}, verdict(weight, tare, fill_in));
      chk(verdict(weight, tare, fill_in), 3'h2);
      chk(coarse_on | fine_on, 1'b0);
      if (m == 1) chk(cut >= 20'h003e8, 1'b1);
      else chk(cc * 16 + fc, 32'h22);
      apb(fill_pkg::A_STATUS, 1'b0, 32'h0);
      chk(q[9], 1'b1);
      $display("fill test %0d done", m);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
